// >>> design/pdc_coder.sv
/*
  Packet line coder: Manchester or whitening on payload and checksum,
  plain NRZ for preamble and sync, one-byte FIFO holding stages.
  Assumes the packet handler feeds plain bits and strobes on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Manchester coding only when selector is 01 and in packet mode.
// - One sent as chips 10, zero as 01; receive inverts this.
// - Programmed rate is chip rate; Manchester bit rate is half.
// - Only payload and checksum are coded; preamble and sync stay NRZ.
// - One constant chip timing from first preamble chip to last checksum chip.
// - Host sees plain NRZ bytes with Manchester active.
// - Whitening and de-whitening when selector is 10.
// - Whitening sequence comes from a nine-bit LFSR.
// - Transmit payload and both checksum bytes XORed with the sequence.
// - Receive XORs the same aligned sequence to recover bits.
// - Whitening keeps one chip per user bit.
// - Host sees plain NRZ bytes with whitening active.
// - With checksum on, two checksum bytes follow payload and are coded.
module pdc_coder #(
  parameter int DIV_W = 16
)(
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic [6:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       tx_start,
  input  wire logic [7:0] tx_payload_len,
  input  wire logic       tx_plain_valid,
  input  wire logic       tx_plain_bit,
  input  wire logic       tx_plain_last,
  output logic            tx_plain_take,
  output logic            tx_chip,
  output logic            tx_chip_strobe,
  output logic            tx_busy,
  output logic            tx_done,
  input  wire logic       rx_sync_found,
  input  wire logic [7:0] rx_payload_len,
  input  wire logic       rx_chip_valid,
  input  wire logic       rx_chip,
  output logic            rx_busy,
  output logic            rx_done,
  output logic            rx_crc_ok
);

  if (DIV_W < 16) begin : g_bad_div
    $error("DIV_W must hold the 16-bit chip rate setting");
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [8:0] lfsr_step(input logic [8:0] s);
    lfsr_step = {s[0] ^ s[pdc_pkg::LFSR_TAP], s[8:1]};
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? pdc_pkg::CRC_POLY : 16'h0000);
  endfunction

  // ************************************************************
  // Reset release
  // ************************************************************
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] modul;
  logic [7:0] rate_hi;
  logic [7:0] rate_lo;
  logic [7:0] pkt_cfg;
  logic [7:0] tx_hold;
  logic       tx_hold_full;
  logic [7:0] rx_hold;
  logic       rx_hold_full;
  logic       rx_overrun;
  logic       rx_code_err;

  wire        wr_fifo   = reg_write && reg_addr == pdc_pkg::ADR_FIFO;
  wire        rd_fifo   = reg_read && reg_addr == pdc_pkg::ADR_FIFO;
  wire        rd_status = reg_read && reg_addr == pdc_pkg::ADR_STATUS;
  wire [1:0]  dc_balance_select = pkt_cfg[pdc_pkg::DC_LO +: 2];
  wire        checksum_enable   = pkt_cfg[pdc_pkg::CRC_EN_BIT];
  wire        packet_mode = modul[pdc_pkg::MODE_LO +: 2] == pdc_pkg::MODE_PACKET;
  wire        manch_on  = packet_mode && dc_balance_select == pdc_pkg::DC_MANCH;
  wire        white_on  = dc_balance_select == pdc_pkg::DC_WHITE;
  wire [15:0] chip_rate_setting = {rate_hi, rate_lo};
  wire [7:0]  status = {1'b0, rx_overrun, rx_busy, tx_busy,
                        rx_code_err, rx_crc_ok, rx_hold_full, tx_hold_full};
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      pdc_pkg::ADR_FIFO:    rd_mux = rx_hold;
      pdc_pkg::ADR_MODUL:   rd_mux = modul;
      pdc_pkg::ADR_RATE_HI: rd_mux = rate_hi;
      pdc_pkg::ADR_RATE_LO: rd_mux = rate_lo;
      pdc_pkg::ADR_STATUS:  rd_mux = status;
      pdc_pkg::ADR_PKT_CFG: rd_mux = pkt_cfg;
      default:              rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      modul     <= pdc_pkg::RST_MODUL;
      rate_hi   <= pdc_pkg::RST_RATE_HI;
      rate_lo   <= pdc_pkg::RST_RATE_LO;
      pkt_cfg   <= pdc_pkg::RST_PKT_CFG;
      reg_rdata <= 8'h00;
    end else begin
      if (reg_write && reg_addr == pdc_pkg::ADR_MODUL) modul <= reg_wdata;
      if (reg_write && reg_addr == pdc_pkg::ADR_RATE_HI) rate_hi <= reg_wdata;
      if (reg_write && reg_addr == pdc_pkg::ADR_RATE_LO) rate_lo <= reg_wdata;
      if (reg_write && reg_addr == pdc_pkg::ADR_PKT_CFG) pkt_cfg <= reg_wdata;
      if (reg_read) reg_rdata <= rd_mux;
    end
  end

  // ************************************************************
  // Chip timing
  // ************************************************************
  // Runs the whole frame, so plain and coded chips share one period
  logic [DIV_W-1:0] div_cnt;
  wire  [DIV_W-1:0] rate_eff = (chip_rate_setting == 16'h0000) ? DIV_W'(1)
                                                               : DIV_W'(chip_rate_setting);
  wire              chip_en  = tx_busy && div_cnt == '0;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
    end else if (!tx_busy || chip_en) begin
      div_cnt <= tx_busy ? rate_eff - DIV_W'(1) : '0;
    end else begin
      div_cnt <= div_cnt - DIV_W'(1);
    end
  end

  // ************************************************************
  // Transmit path
  // ************************************************************
  pdc_pkg::pdc_tx_state_type tx_state;
  logic [15:0] tx_shift;
  logic [4:0]  tx_bits_left;
  logic        tx_loaded;
  logic        tx_half;
  logic [8:0]  tx_lfsr;
  logic [15:0] tx_crc;
  logic [7:0]  tx_len;
  logic [7:0]  tx_bytes;
  logic        tx_second_half;

  wire tx_coded    = tx_state == pdc_pkg::TX_DATA || tx_state == pdc_pkg::TX_CRC;
  wire tx_emit     = chip_en && tx_coded && tx_loaded;
  wire tx_cur      = tx_shift[15];
  wire tx_bit_done = tx_emit && (!manch_on || tx_half);
  wire tx_unit_end = tx_bit_done && tx_bits_left == 5'h01;
  wire tx_load     = tx_state == pdc_pkg::TX_DATA && !tx_loaded && tx_hold_full
                     && tx_bytes != tx_len;
  wire tx_fin_data = tx_state == pdc_pkg::TX_DATA && !tx_loaded && tx_bytes == tx_len;
  wire tx_code_chip = manch_on ? (tx_half ? ~tx_cur : tx_cur)
                               : tx_cur ^ (white_on & tx_lfsr[0]);
  assign tx_plain_take = chip_en && tx_state == pdc_pkg::TX_PLAIN;
  assign tx_busy       = tx_state != pdc_pkg::TX_IDLE;
  wire tx_plain_go     = tx_plain_take && tx_plain_valid;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_hold      <= 8'h00;
      tx_hold_full <= 1'b0;
    end else begin
      if (wr_fifo && !tx_hold_full) tx_hold <= reg_wdata;
      tx_hold_full <= (wr_fifo && !tx_hold_full) || (tx_hold_full && !tx_load);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_chip        <= 1'b0;
      tx_chip_strobe <= 1'b0;
      tx_second_half <= 1'b0;
    end else begin
      tx_chip_strobe <= tx_plain_go || tx_emit;
      tx_second_half <= tx_emit && manch_on && tx_half;
      if (tx_plain_go) tx_chip <= tx_plain_bit;
      else if (tx_emit) tx_chip <= tx_code_chip;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state <= pdc_pkg::TX_IDLE;
      tx_shift <= 16'h0000;
      tx_bits_left <= 5'h00;
      tx_loaded <= 1'b0;
      tx_half  <= 1'b0;
      tx_lfsr  <= pdc_pkg::LFSR_SEED;
      tx_crc   <= pdc_pkg::CRC_INIT;
      tx_len   <= 8'h00;
      tx_bytes <= 8'h00;
      tx_done  <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      if (tx_emit) tx_half <= manch_on ? ~tx_half : 1'b0;
      if (tx_bit_done) begin
        tx_shift     <= {tx_shift[14:0], 1'b0};
        tx_bits_left <= tx_bits_left - 5'h01;
        tx_lfsr      <= lfsr_step(tx_lfsr);
        if (tx_state == pdc_pkg::TX_DATA) tx_crc <= crc_step(tx_crc, tx_cur);
      end
      case (tx_state)
        pdc_pkg::TX_IDLE: begin
          if (tx_start) begin
            tx_state <= pdc_pkg::TX_PLAIN;
            tx_len   <= tx_payload_len;
          end
        end
        pdc_pkg::TX_PLAIN: begin
          if (tx_plain_go && tx_plain_last) begin
            tx_state  <= pdc_pkg::TX_DATA;
            tx_lfsr   <= pdc_pkg::LFSR_SEED;
            tx_crc    <= pdc_pkg::CRC_INIT;
            tx_bytes  <= 8'h00;
            tx_loaded <= 1'b0;
            tx_half   <= 1'b0;
          end
        end
        pdc_pkg::TX_DATA: begin
          if (tx_load) begin
            tx_shift     <= {tx_hold, 8'h00};
            tx_bits_left <= pdc_pkg::BITS_BYTE;
            tx_loaded    <= 1'b1;
            tx_bytes     <= tx_bytes + 8'h01;
          end else if (tx_unit_end) begin
            tx_loaded <= 1'b0;
          end else if (tx_fin_data && checksum_enable) begin
            tx_state     <= pdc_pkg::TX_CRC;
            tx_shift     <= ~tx_crc;
            tx_bits_left <= pdc_pkg::BITS_CRC;
            tx_loaded    <= 1'b1;
          end else if (tx_fin_data) begin
            tx_state <= pdc_pkg::TX_IDLE;
            tx_done  <= 1'b1;
          end
        end
        pdc_pkg::TX_CRC: begin
          if (tx_unit_end) begin
            tx_state  <= pdc_pkg::TX_IDLE;
            tx_loaded <= 1'b0;
            tx_done   <= 1'b1;
          end
        end
        default: tx_state <= pdc_pkg::TX_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Receive path
  // ************************************************************
  pdc_pkg::pdc_rx_state_type rx_state;
  logic [15:0] rx_shift;
  logic [4:0]  rx_bits;
  logic        rx_half;
  logic        rx_first;
  logic [8:0]  rx_lfsr;
  logic [15:0] rx_crc;
  logic [7:0]  rx_len;
  logic [7:0]  rx_bytes;

  wire rx_take     = rx_chip_valid && rx_state != pdc_pkg::RX_IDLE;
  wire rx_bit_rdy  = rx_take && (!manch_on || rx_half);
  wire rx_bit      = manch_on ? rx_first
                              : rx_chip ^ (white_on & rx_lfsr[0]);
  wire rx_pair_bad = rx_take && manch_on && rx_half && rx_first == rx_chip;
  wire [4:0] rx_unit = (rx_state == pdc_pkg::RX_DATA) ? pdc_pkg::BITS_BYTE
                                                      : pdc_pkg::BITS_CRC;
  wire rx_unit_end = rx_bit_rdy && rx_bits == rx_unit - 5'h01;
  wire rx_push     = rx_unit_end && rx_state == pdc_pkg::RX_DATA;
  wire [15:0] rx_next_shift = {rx_shift[14:0], rx_bit};
  wire rx_fin_data = rx_state == pdc_pkg::RX_DATA && rx_bytes == rx_len && rx_bits == 5'h00;
  assign rx_busy   = rx_state != pdc_pkg::RX_IDLE;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_hold      <= 8'h00;
      rx_hold_full <= 1'b0;
      rx_overrun   <= 1'b0;
      rx_code_err  <= 1'b0;
    end else begin
      if (rx_push) rx_hold <= rx_next_shift[7:0];
      rx_hold_full <= rx_push || (rx_hold_full && !rd_fifo);
      rx_overrun   <= (rx_push && rx_hold_full && !rd_fifo) || (rx_overrun && !rd_status);
      rx_code_err  <= rx_pair_bad || (rx_code_err && !rd_status);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state  <= pdc_pkg::RX_IDLE;
      rx_shift  <= 16'h0000;
      rx_bits   <= 5'h00;
      rx_half   <= 1'b0;
      rx_first  <= 1'b0;
      rx_lfsr   <= pdc_pkg::LFSR_SEED;
      rx_crc    <= pdc_pkg::CRC_INIT;
      rx_len    <= 8'h00;
      rx_bytes  <= 8'h00;
      rx_done   <= 1'b0;
      rx_crc_ok <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (rx_take) begin
        rx_half <= manch_on ? ~rx_half : 1'b0;
        if (!rx_half) rx_first <= rx_chip;
      end
      if (rx_bit_rdy) begin
        rx_shift <= rx_next_shift;
        rx_bits  <= rx_unit_end ? 5'h00 : rx_bits + 5'h01;
        rx_lfsr  <= lfsr_step(rx_lfsr);
        if (rx_state == pdc_pkg::RX_DATA) rx_crc <= crc_step(rx_crc, rx_bit);
      end
      if (rx_sync_found) begin
        rx_state  <= pdc_pkg::RX_DATA;
        rx_lfsr   <= pdc_pkg::LFSR_SEED;
        rx_crc    <= pdc_pkg::CRC_INIT;
        rx_bits   <= 5'h00;
        rx_bytes  <= 8'h00;
        rx_half   <= 1'b0;
        rx_len    <= rx_payload_len;
        rx_crc_ok <= 1'b0;
      end else begin
        case (rx_state)
          pdc_pkg::RX_IDLE: ;
          pdc_pkg::RX_DATA: begin
            if (rx_push) begin
              rx_bytes <= rx_bytes + 8'h01;
            end else if (rx_fin_data) begin
              rx_state <= checksum_enable ? pdc_pkg::RX_CRC : pdc_pkg::RX_IDLE;
              rx_done  <= !checksum_enable;
            end
          end
          pdc_pkg::RX_CRC: begin
            if (rx_unit_end) begin
              rx_state  <= pdc_pkg::RX_IDLE;
              rx_done   <= 1'b1;
              rx_crc_ok <= rx_next_shift == ~rx_crc;
            end
          end
          default: rx_state <= pdc_pkg::RX_IDLE;
        endcase
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  logic tx_prev_chip;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) tx_prev_chip <= 1'b0;
    else if (tx_chip_strobe) tx_prev_chip <= tx_chip;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence seq_last_plain;
    tx_plain_go && tx_plain_last;
  endsequence
  sequence seq_data_seeded;
    tx_state == pdc_pkg::TX_DATA && tx_lfsr == pdc_pkg::LFSR_SEED;
  endsequence

  // Outside packet mode every emitted chip must close its bit
  AST_MANCH_GATE: assert property (
      tx_emit && !packet_mode |-> tx_bit_done)
    else $error("Manchester pairing used outside packet mode");
  AST_MANCH_PAIR: assert property (
      tx_chip_strobe && tx_second_half |-> tx_chip != tx_prev_chip)
    else $error("Manchester chip pair not complementary");
  AST_PLAIN_NRZ: assert property (
      tx_plain_go |=> tx_chip_strobe && tx_chip == $past(tx_plain_bit))
    else $error("Plain chip not passed uncoded");
  AST_CHIP_GAP: assert property (chip_en && rate_eff > 1 |=> !chip_en)
    else $error("Chip enable came early");
  AST_WHITE_ONE_CHIP: assert property (
      tx_emit && !manch_on |=> tx_bits_left == $past(tx_bits_left) - 5'h01)
    else $error("Whitened bit took more than one chip");
  AST_LFSR_SEED: assert property (seq_last_plain |=> seq_data_seeded)
    else $error("Whitening register not seeded at payload start");
  AST_LFSR_MOVES: assert property (tx_bit_done |=> tx_lfsr != $past(tx_lfsr))
    else $error("Whitening sequence did not advance");
  AST_CRC_FOLLOWS: assert property (
      tx_fin_data && checksum_enable
      |=> tx_state == pdc_pkg::TX_CRC ##0 tx_bits_left == pdc_pkg::BITS_CRC)
    else $error("Checksum did not follow payload");
  AST_RX_PUSH: assert property (
      rx_push |=> rx_hold_full && rx_hold == $past(rx_next_shift[7:0]))
    else $error("Received byte not delivered");

endmodule

`default_nettype wire

// >>> include/pdc_pkg.sv
/*
  Constants, register map and state types of the packet line coder.
  Assumes the register port addresses the documented 7-bit register space.
*/
package pdc_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [6:0] ADR_FIFO      = 7'h00;
  localparam logic [6:0] ADR_MODUL     = 7'h02;
  localparam logic [6:0] ADR_RATE_HI   = 7'h03;
  localparam logic [6:0] ADR_RATE_LO   = 7'h04;
  localparam logic [6:0] ADR_STATUS    = 7'h28;
  localparam logic [6:0] ADR_PKT_CFG   = 7'h37;

  localparam logic [7:0] RST_MODUL     = 8'h00;
  localparam logic [7:0] RST_RATE_HI   = 8'h1a;
  localparam logic [7:0] RST_RATE_LO   = 8'h0b;
  localparam logic [7:0] RST_PKT_CFG   = 8'h10;

  // ************************************************************
  // Field layout
  // ************************************************************
  localparam int         MODE_LO       = 5;
  localparam int         DC_LO         = 5;
  localparam int         CRC_EN_BIT    = 4;
  localparam logic [1:0] MODE_PACKET   = 2'h0;
  localparam logic [1:0] DC_NONE       = 2'h0;
  localparam logic [1:0] DC_MANCH      = 2'h1;
  localparam logic [1:0] DC_WHITE      = 2'h2;
  localparam logic [1:0] MANCH_ONE     = 2'h2;
  localparam logic [1:0] MANCH_ZERO    = 2'h1;

  // ************************************************************
  // Coder constants
  // ************************************************************
  localparam int         LFSR_W        = 9;
  localparam int         LFSR_TAP      = 5;
  localparam logic [8:0] LFSR_SEED     = 9'h1ff;
  localparam logic [15:0] CRC_INIT     = 16'h1d0f;
  localparam logic [15:0] CRC_POLY     = 16'h1021;
  localparam logic [4:0] BITS_BYTE     = 5'h08;
  localparam logic [4:0] BITS_CRC      = 5'h10;

  typedef enum logic [1:0] {TX_IDLE, TX_PLAIN, TX_DATA, TX_CRC} pdc_tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_CRC} pdc_rx_state_type;

endpackage

// >>> sim/pdc_radio_model.sv
/*
  Radio side model: feeds a coded chip stream into the receive port.
  Assumes chips are spaced by the programmed chip period in ref_clk cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module pdc_radio_model #(
  parameter int RATE = 6
)(
  input  wire logic ref_clk,
  output logic      rx_sync_found,
  output logic      rx_chip_valid,
  output logic      rx_chip
);
  logic active;

  initial begin
    active        = 1'b0;
    rx_sync_found = 1'b0;
    rx_chip_valid = 1'b0;
    rx_chip       = 1'b0;
  end

  // Idle line wanders, so a stale chip never passes for a real one
  always @(posedge ref_clk) begin
    if (!active)
      rx_chip <= ~rx_chip;
  end

  // ************************************************************
  // Frame replay
  // ************************************************************
  task automatic play(input logic chips [$]);
    active = 1'b1;
    @(posedge ref_clk);
    rx_sync_found <= 1'b1;
    @(posedge ref_clk);
    rx_sync_found <= 1'b0;
    foreach (chips[i]) begin
      repeat (RATE - 1) begin
        rx_chip_valid <= 1'b0;
        rx_chip       <= ~rx_chip;
        @(posedge ref_clk);
      end
      rx_chip_valid <= 1'b1;
      rx_chip       <= chips[i];
      @(posedge ref_clk);
    end
    rx_chip_valid <= 1'b0;
    active = 1'b0;
  endtask
endmodule

`default_nettype wire

// >>> sim/test_packet_dc_free_coder.sv
/*
  Self-checking bench of the packet line coder with a radio model.
  Assumes the coder package and design are compiled before this file.
*/
`timescale 1ns/1ps
`default_nettype none

module test_packet_dc_free_coder;
  localparam int         RATE  = 6;
  localparam logic [3:0] PLAIN = 4'hb;
  logic       ref_clk        = 1'b0;
  logic       nrst           = 1'b0;
  logic [6:0] reg_addr       = 7'h00;
  logic [7:0] reg_wdata      = 8'h00;
  logic       reg_write      = 1'b0;
  logic       reg_read       = 1'b0;
  logic       tx_start       = 1'b0;
  logic [7:0] tx_payload_len = 8'h00;
  logic [7:0] rx_payload_len = 8'h00;
  logic       tx_plain_valid = 1'b0;
  logic       tx_plain_bit   = 1'b0;
  logic       tx_plain_last  = 1'b0;
  logic [7:0] reg_rdata;
  logic       tx_plain_take;
  logic       tx_chip;
  logic       tx_chip_strobe;
  logic       tx_busy;
  logic       tx_done;
  logic       rx_sync_found;
  logic       rx_chip_valid;
  logic       rx_chip;
  logic       rx_busy;
  logic       rx_done;
  logic       rx_crc_ok;
  int         fail_count     = 0;
  int         compares       = 0;
  int         seed           = 8;
  int         gap            = 0;
  int         dones          = 0;
  int         frames         = 0;
  logic       first          = 1'b1;
  logic       rd_pend        = 1'b0;
  logic [8:0] note;
  logic [7:0] rv;
  logic       chip_q [$];
  logic       crc_q [$];
  logic [8:0] rd_q [$];

  always #10 ref_clk = ~ref_clk;

  pdc_coder #(.DIV_W(16)) i_dut (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .tx_start(tx_start), .tx_payload_len(tx_payload_len),
    .tx_plain_valid(tx_plain_valid), .tx_plain_bit(tx_plain_bit),
    .tx_plain_last(tx_plain_last), .tx_plain_take(tx_plain_take), .tx_chip(tx_chip),
    .tx_chip_strobe(tx_chip_strobe), .tx_busy(tx_busy), .tx_done(tx_done),
    .rx_sync_found(rx_sync_found), .rx_payload_len(rx_payload_len),
    .rx_chip_valid(rx_chip_valid), .rx_chip(rx_chip), .rx_busy(rx_busy),
    .rx_done(rx_done), .rx_crc_ok(rx_crc_ok)
  );

  pdc_radio_model #(.RATE(RATE)) i_radio (
    .ref_clk(ref_clk), .rx_sync_found(rx_sync_found),
    .rx_chip_valid(rx_chip_valid), .rx_chip(rx_chip)
  );

  // ************************************************************
  // Reporting
  // ************************************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic stall;
    fail_count++;
    $display("BAD wait expected done seen timeout");
    wrap_up();
  endtask

  // ************************************************************
  // Register port and handshakes
  // ************************************************************
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [6:0] a, input logic chk, input logic [7:0] e,
                    output logic [7:0] v);
    reg_addr <= a;
    reg_read <= 1'b1;
    rd_q.push_back({chk, e});
    @(posedge ref_clk);
    reg_read <= 1'b0;
    @(posedge ref_clk);
    v = reg_rdata;
  endtask

  // Status bit 0 is transmit holding full, bit 1 receive holding full
  task automatic poll(input int b, input logic lvl);
    logic [7:0] v;
    v = {8{~lvl}};
    for (int n = 0; n < 400 && v[b] !== lvl; n++)
      rd(pdc_pkg::ADR_STATUS, 1'b0, 8'h00, v);
    if (v[b] !== lvl)
      stall();
  endtask

  task automatic wait_lvl(ref logic s, input logic lvl);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (s !== lvl && n < 4000) begin
      n++;
      @(negedge ref_clk);
    end
    if (s !== lvl)
      stall();
    @(posedge ref_clk);
  endtask

  // ************************************************************
  // One frame out and back
  // ************************************************************
  task automatic frame(input logic [1:0] sel, input logic pkt, input logic flip);
    logic [7:0]  pay [2];
    logic        bits [$];
    logic        coded [$];
    logic [15:0] crc;
    logic [8:0]  lf;
    logic [7:0]  v;
    crc = pdc_pkg::CRC_INIT;
    lf  = pdc_pkg::LFSR_SEED;
    frames++;
    wr(pdc_pkg::ADR_MODUL, pkt ? 8'h00 : 8'h20);
    wr(pdc_pkg::ADR_PKT_CFG, {1'b0, sel, 5'h10});
    for (int k = 0; k < 2; k++) begin
      pay[k] = 8'($random(seed));
      for (int b = 7; b >= 0; b--) begin
        bits.push_back(pay[k][b]);
        crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ pay[k][b]) ? pdc_pkg::CRC_POLY : 16'h0000);
      end
    end
    for (int b = 15; b >= 0; b--)
      bits.push_back(~crc[b]);
    foreach (bits[i]) begin
      if (sel == pdc_pkg::DC_MANCH && pkt) begin
        coded.push_back(bits[i]);
        coded.push_back(~bits[i]);
      end else if (sel == pdc_pkg::DC_WHITE) begin
        coded.push_back(bits[i] ^ lf[0]);
        lf = {lf[0] ^ lf[pdc_pkg::LFSR_TAP], lf[8:1]};
      end else
        coded.push_back(bits[i]);
    end
    for (int i = 3; i >= 0; i--)
      chip_q.push_back(PLAIN[i]);
    foreach (coded[i])
      chip_q.push_back(coded[i]);
    wr(pdc_pkg::ADR_FIFO, pay[0]);
    tx_payload_len <= 8'h02;
    tx_start       <= 1'b1;
    tx_plain_valid <= 1'b1;
    tx_plain_bit   <= PLAIN[3];
    @(posedge ref_clk);
    tx_start <= 1'b0;
    for (int i = 3; i >= 0; i--) begin
      tx_plain_bit  <= PLAIN[i];
      tx_plain_last <= (i == 0);
      wait_lvl(tx_plain_take, 1'b1);
    end
    tx_plain_valid <= 1'b0;
    tx_plain_last  <= 1'b0;
    poll(0, 1'b0);
    wr(pdc_pkg::ADR_FIFO, pay[1]);
    wait_lvl(tx_busy, 1'b0);
    // Last strobe is popped by the watcher on this edge; look one edge later
    @(posedge ref_clk);
    check("tx_chips_left", 16'(chip_q.size()), 16'h0000);
    check("tx_done_count", 16'(dones), 16'(frames));
    if (flip)
      coded[coded.size() - 1] = ~coded[coded.size() - 1];
    crc_q.push_back(!flip);
    rx_payload_len <= 8'h02;
    fork
      i_radio.play(coded);
      begin
        for (int k = 0; k < 2; k++) begin
          poll(1, 1'b1);
          rd(pdc_pkg::ADR_FIFO, 1'b1, pay[k], v);
        end
      end
    join
    wait_lvl(rx_busy, 1'b0);
    repeat (2) @(posedge ref_clk);
    check("rx_done_seen", 16'(crc_q.size()), 16'h0000);
  endtask

  // ************************************************************
  // Result watcher
  // ************************************************************
  always @(posedge ref_clk) begin
    rd_pend <= reg_read;
    gap     <= tx_chip_strobe ? 1 : gap + 1;
    if (rd_pend) begin
      note = rd_q.pop_front();
      if (note[8])
        check("reg_rdata", {8'h00, reg_rdata}, {8'h00, note[7:0]});
    end
    if (tx_chip_strobe) begin
      check("tx_chip", {15'h0000, tx_chip}, {15'h0000, chip_q.pop_front()});
      if (!first)
        check("chip_gap", 16'(gap), 16'(RATE));
      first <= 1'b0;
    end
    if (tx_start)
      first <= 1'b1;
    if (tx_done)
      dones <= dones + 1;
    if (rx_done)
      check("rx_crc_ok", {15'h0000, rx_crc_ok}, {15'h0000, crc_q.pop_front()});
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    stall();
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(pdc_pkg::ADR_MODUL, 1'b1, pdc_pkg::RST_MODUL, rv);
    rd(pdc_pkg::ADR_RATE_HI, 1'b1, pdc_pkg::RST_RATE_HI, rv);
    rd(pdc_pkg::ADR_RATE_LO, 1'b1, pdc_pkg::RST_RATE_LO, rv);
    rd(pdc_pkg::ADR_PKT_CFG, 1'b1, pdc_pkg::RST_PKT_CFG, rv);
    rd(7'h05, 1'b1, 8'h00, rv);
    wr(pdc_pkg::ADR_RATE_HI, 8'h00);
    wr(pdc_pkg::ADR_RATE_LO, 8'(RATE));
    rd(pdc_pkg::ADR_RATE_LO, 1'b1, 8'(RATE), rv);
    for (int s = 0; s < 4; s++)
      frame(2'(s), 1'b1, s == 3);
    frame(pdc_pkg::DC_MANCH, 1'b0, 1'b0);
    wrap_up();
  end
endmodule

`default_nettype wire
